// File: src/edge_irq_pkg.sv
package edge_irq_pkg;
  // ****************************************************
  // Register byte offsets
  // ****************************************************
  localparam logic [7:0] OFF_EDGE_FIRST  = 8'h00;
  localparam logic [7:0] OFF_EDGE_SECOND = 8'h04;
  localparam logic [7:0] OFF_EDGE_TK     = 8'h08;
  localparam logic [7:0] OFF_FLAGS       = 8'h0C;
  localparam logic [7:0] OFF_PINS        = 8'h10;
  localparam logic [7:0] OFF_STANDBY     = 8'h14;
  localparam logic [7:0] OFF_KEY_DIR     = 8'h18;

  // ****************************************************
  // Field positions and encodings
  // ****************************************************
  localparam int          FIRST_NOISE_BIT = 2;
  localparam int          FIRST_SLOW_BIT  = 3;
  localparam int          FLAG_BOTH       = 0;
  localparam int          FLAG_FIRST      = 1;
  localparam int          FLAG_SECOND     = 2;
  localparam int          FLAG_TEST       = 3;
  localparam int          FLAG_KEY        = 4;
  localparam logic [1:0]  MODE_RISE       = 2'h0;
  localparam logic [1:0]  MODE_FALL       = 2'h1;
  localparam logic [1:0]  MODE_BOTH       = 2'h2;
  localparam logic [1:0]  MODE_OFF        = 2'h3;
  localparam logic [1:0]  TK_TEST_RISE    = 2'h0;
  localparam logic [1:0]  TK_KEY          = 2'h1;

  // ****************************************************
  // Reset values and timing
  // ****************************************************
  localparam logic [3:0]  EDGE_FIRST_RST  = 4'h0;
  localparam logic        EDGE_SECOND_RST = 1'b0;
  localparam logic [1:0]  EDGE_TK_RST     = 2'h0;
  localparam logic [4:0]  FLAGS_RST       = 5'h00;
  localparam logic [5:0]  NOISE_DIV_FAST  = 6'h04;
  localparam logic [5:0]  NOISE_DIV_SLOW  = 6'h20;
endpackage : edge_irq_pkg

// File: src/edge_irq_detect.sv
// Operation
// - Both-edge input sets its request flag on any level change.
// - Both-edge input is asynchronous; accepted once held stable.
// - Both-edge input event releases standby.
// - First edge mode field: rising, falling, both, or disabled.
// - Second edge mode bit: rising or falling for second input.
// - First input passes a noise rejecter with two sampling rates.
// - Second input is asynchronous, accepted on sufficient high or low width, per its edge mode bit.
// - Reset clears first and second edge mode, selecting rising edge.
// - Selectable inputs release standby, first not while filtered.
// - Test edge input, when selected, sets the internal test flag.
// - Test edge input is asynchronous, accepted on sufficient width.
// - Reset clears third mode register: rising test edge sets flag.
// - Test edge event releases standby.
// - Eight key inputs watched in parallel for falling edges.
// - Third edge mode register selects how key events report.
// - After reset key pins are plain inputs.
// - Active-low reset overrides everything and releases standby.
// - Key events set a polled flag, not a vectored request.
//
// Design decisions made here: register access over APB and the register addresses.
module edge_irq_detect
  import edge_irq_pkg::*;
(
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic        both_edge_vector_in,
  input  wire logic        noise_filtered_vector_in,
  input  wire logic        async_vector_in,
  input  wire logic        test_edge_in,
  input  wire logic [7:0]  key_event_inputs,
  output logic      [7:0]  key_oe,
  // Core side
  input  wire logic [2:0]  vector_ack,
  output logic      [2:0]  vector_req,
  output logic             test_edge_flag,
  output logic             key_flag,
  output logic             standby,
  output logic             wake
);

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic [1:0] mode);
    logic r;
    r = 1'b0;
    unique case (mode)
      MODE_RISE: r = ~prev & cur;
      MODE_FALL: r = prev & ~cur;
      MODE_BOTH: r = prev ^ cur;
      MODE_OFF:  r = 1'b0;
    endcase
    return r;
  endfunction : edge_hit

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [11:0] pin_meta_r;
  logic [11:0] pin_sync_r;
  logic [11:0] pin_prev_r;
  logic [11:0] pin_raw;
  assign pin_raw = {key_event_inputs, test_edge_in, async_vector_in,
                    noise_filtered_vector_in, both_edge_vector_in};

  // Wake needs a running pclk; no clockless path is offered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
      pin_prev_r <= '0;
    end else begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  // ****************************************************
  // Noise rejecter
  // ****************************************************
  logic [5:0] noise_cnt_r;
  logic       noise_smp_r;
  logic       noise_lvl_r;
  logic       noise_lvl_d_r;
  logic [3:0] edge_first_r;
  logic [5:0] noise_div;
  logic       noise_tick;
  assign noise_div  = edge_first_r[FIRST_SLOW_BIT] ? NOISE_DIV_SLOW : NOISE_DIV_FAST;
  assign noise_tick = (noise_cnt_r == 6'h00);

  // A level is taken only after two agreeing samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      noise_cnt_r   <= 6'h00;
      noise_smp_r   <= 1'b0;
      noise_lvl_r   <= 1'b0;
      noise_lvl_d_r <= 1'b0;
    end else begin
      noise_cnt_r   <= noise_tick ? noise_div - 6'h01 : noise_cnt_r - 6'h01;
      noise_lvl_d_r <= noise_lvl_r;
      if (noise_tick) begin
        noise_smp_r <= pin_sync_r[1];
        if (noise_smp_r == pin_sync_r[1]) begin
          noise_lvl_r <= noise_smp_r;
        end
      end
    end
  end

  // ****************************************************
  // Edge events
  // ****************************************************
  logic [1:0] edge_sel_test_key_r;
  logic       edge_sel_second_r;
  logic       ev_both;
  logic       ev_first;
  logic       ev_second;
  logic       ev_test;
  logic       ev_key;
  logic       noise_on;
  assign noise_on  = edge_first_r[FIRST_NOISE_BIT];
  assign ev_both   = pin_prev_r[0] ^ pin_sync_r[0];
  assign ev_first  = noise_on ?
                     edge_hit(noise_lvl_d_r, noise_lvl_r, edge_first_r[1:0]) :
                     edge_hit(pin_prev_r[1], pin_sync_r[1], edge_first_r[1:0]);
  assign ev_second = edge_hit(pin_prev_r[2], pin_sync_r[2],
                              {1'b0, edge_sel_second_r});
  assign ev_key    = |(pin_prev_r[11:4] & ~pin_sync_r[11:4]);
  assign ev_test   = (edge_sel_test_key_r[1:0] == TK_TEST_RISE) ?
                     (~pin_prev_r[3] & pin_sync_r[3]) :
                     ((edge_sel_test_key_r[1:0] == TK_KEY) & ev_key);

  // ****************************************************
  // APB slave
  // ****************************************************
  logic        setup;
  logic        wr_en;
  logic        hit;
  logic [31:0] rd_mux;
  logic [4:0]  flags_r;
  logic        standby_r;
  logic        key_dir_r;
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;

  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFF_EDGE_FIRST:  rd_mux[3:0]  = edge_first_r;
      OFF_EDGE_SECOND: rd_mux[0]    = edge_sel_second_r;
      OFF_EDGE_TK:     rd_mux[1:0]  = edge_sel_test_key_r[1:0];
      OFF_FLAGS:       rd_mux[4:0]  = flags_r;
      OFF_PINS:        rd_mux[11:0] = pin_sync_r;
      OFF_STANDBY:     rd_mux[0]    = standby_r;
      OFF_KEY_DIR:     rd_mux[0]    = key_dir_r;
      default:         hit          = 1'b0;
    endcase
  end

  // One registered wait-free answer in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************************
  // Mode registers
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_first_r        <= EDGE_FIRST_RST;
      edge_sel_second_r   <= EDGE_SECOND_RST;
      edge_sel_test_key_r <= EDGE_TK_RST;
      key_dir_r           <= 1'b0;
    end else if (wr_en) begin
      if (paddr == OFF_EDGE_FIRST) edge_first_r <= pwdata[3:0];
      if (paddr == OFF_EDGE_SECOND) edge_sel_second_r <= pwdata[0];
      if (paddr == OFF_EDGE_TK) edge_sel_test_key_r <= pwdata[1:0];
      if (paddr == OFF_KEY_DIR) key_dir_r <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_oe <= 8'h00;
    end else begin
      key_oe <= {8{key_dir_r}};
    end
  end

  // ****************************************************
  // Request and test flags
  // ****************************************************
  logic [4:0] flag_set;
  logic [4:0] flag_clr;
  assign flag_set = {ev_key, ev_test, ev_second, ev_first, ev_both};
  assign flag_clr = ((wr_en && paddr == OFF_FLAGS) ? pwdata[4:0] : 5'h00)
                    | {2'b00, vector_ack};

  // Set beats a clear landing on the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= FLAGS_RST;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_req     <= 3'h0;
      test_edge_flag <= 1'b0;
      key_flag       <= 1'b0;
    end else begin
      vector_req     <= flags_r[FLAG_SECOND:FLAG_BOTH];
      test_edge_flag <= flags_r[FLAG_TEST];
      key_flag       <= flags_r[FLAG_KEY];
    end
  end

  // ****************************************************
  // Standby release
  // ****************************************************
  logic wake_ev;
  assign wake_ev = ev_both
                 | (ev_first & ~noise_on)
                 | ev_second
                 | ev_test;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_r <= 1'b0;
      standby   <= 1'b0;
      wake      <= 1'b0;
    end else begin
      wake    <= standby_r & wake_ev;
      standby <= standby_r & ~wake_ev;
      if (standby_r && wake_ev) begin
        standby_r <= 1'b0;
      end else if (wr_en && paddr == OFF_STANDBY) begin
        standby_r <= pwdata[0];
      end
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  both_edge_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_sync_r[0] != pin_prev_r[0]) |=> flags_r[FLAG_BOTH])
    else $error("both-edge change did not set flag");

  first_disabled_a: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_first_r[1:0] == MODE_OFF) |-> !ev_first)
    else $error("disabled first input raised event");

  second_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!edge_sel_second_r && $rose(pin_sync_r[2])) |=> flags_r[FLAG_SECOND])
    else $error("second input rising edge missed");

  noise_no_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    (noise_on && !ev_both && !ev_second && !ev_test && standby_r) |=> !wake)
    else $error("filtered first input woke standby");

  test_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_sel_test_key_r[1:0] == TK_TEST_RISE && $rose(pin_sync_r[3]))
    |=> flags_r[FLAG_TEST] ##1 test_edge_flag)
    else $error("test edge did not reach test flag");

  key_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|(pin_prev_r[11:4] & ~pin_sync_r[11:4])) |=> flags_r[FLAG_KEY])
    else $error("key falling edge missed");

  flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_r[FLAG_TEST] && !flag_clr[FLAG_TEST]) |=> flags_r[FLAG_TEST])
    else $error("test flag dropped without clear");

  standby_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    (standby_r && ev_both) |=> (wake && !standby_r) ##1 !wake)
    else $error("both-edge event did not release standby");

  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> (pready && (pslverr == !$past(hit))))
    else $error("apb answer wrong");

  pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  second_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_sel_second_r && $fell(pin_sync_r[2])) |=> flags_r[FLAG_SECOND])
    else $error("second input falling edge missed");

  noise_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    !noise_tick |=> $stable(noise_lvl_r))
    else $error("filtered level moved between samples");

  noise_period_a: assert property (@(posedge pclk) disable iff (!presetn)
    noise_tick |=> (noise_cnt_r == $past(noise_div) - 6'h01))
    else $error("sampling period not reloaded");

  first_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    (standby_r && ev_first && !noise_on) |=> (wake && !standby_r))
    else $error("unfiltered first input did not release standby");

  test_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    (standby_r && ev_test) |=> (wake && !standby_r))
    else $error("test event did not release standby");

  key_test_a: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_sel_test_key_r == TK_KEY && ev_key) |=> flags_r[FLAG_TEST])
    else $error("key event did not set test flag");

  key_no_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_key && !ev_both && !ev_first && !ev_second &&
     flags_r[FLAG_SECOND:FLAG_BOTH] == 3'h0) |=> (flags_r[FLAG_SECOND:FLAG_BOTH] == 3'h0))
    else $error("key event raised a vectored request");

  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    (flag_set != 5'h00) |=> ((flags_r & $past(flag_set)) == $past(flag_set)))
    else $error("flag event lost");

  req_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_r[FLAG_SECOND:FLAG_BOTH] != 3'h0)
    |=> (vector_req == $past(flags_r[FLAG_SECOND:FLAG_BOTH])))
    else $error("vectored request does not follow flags");

  key_input_a: assert property (@(posedge pclk) disable iff (!presetn)
    !key_dir_r |=> (key_oe == 8'h00))
    else $error("key pins driven while set as inputs");
endmodule : edge_irq_detect

// File: verif/pin_source.sv
module pin_source (
  // Clock
  input  wire logic       pclk,
  // Pins
  output logic            both_edge_vector_in,
  output logic            noise_filtered_vector_in,
  output logic            async_vector_in,
  output logic            test_edge_in,
  output logic      [7:0] key_event_inputs
);
  timeunit 1ns;
  timeprecision 1ps;

  // Keys idle high, as with their pull-ups; vector pins idle low
  logic [11:0] lv_r = 12'hFF0;

  assign both_edge_vector_in      = lv_r[0];
  assign noise_filtered_vector_in = lv_r[1];
  assign async_vector_in          = lv_r[2];
  assign test_edge_in             = lv_r[3];
  assign key_event_inputs         = lv_r[11:4];

  // Levels change just after an edge and hold until the next call
  task automatic put(input logic [11:0] v);
    @(posedge pclk);
    lv_r <= v;
  endtask : put
endmodule : pin_source

// File: verif/edge_irq_detect_tb.sv
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module edge_irq_detect_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import edge_irq_pkg::*;

  localparam logic [11:0] I = 12'hFF0;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic        pready, pslverr, err;
  logic        be_in, nf_in, as_in, te_in;
  logic [7:0]  keys, key_oe;
  logic [2:0]  vector_ack = 3'h0;
  logic [2:0]  vector_req;
  logic        test_edge_flag, key_flag, standby, wake;
  int          n_fail = 0;
  int          tests_run = 0;
  int          wake_cnt = 0;

  always #20 pclk = ~pclk;

  // Wake is a one-cycle pulse, so count it rather than sample it
  always @(posedge pclk) if (wake === 1'b1) wake_cnt <= wake_cnt + 1;

  edge_irq_detect u_edge_irq_detect (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .both_edge_vector_in(be_in), .noise_filtered_vector_in(nf_in),
    .async_vector_in(as_in), .test_edge_in(te_in), .key_event_inputs(keys),
    .key_oe(key_oe), .vector_ack(vector_ack), .vector_req(vector_req),
    .test_edge_flag(test_edge_flag), .key_flag(key_flag), .standby(standby), .wake(wake)
  );

  pin_source u_pin_source (
    .pclk(pclk), .both_edge_vector_in(be_in), .noise_filtered_vector_in(nf_in),
    .async_vector_in(as_in), .test_edge_in(te_in), .key_event_inputs(keys)
  );

  // ****************************************************
  // Bus and pin tasks
  // ****************************************************
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      n_fail++;
      end_sim();
    end
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic flg(input logic [4:0] exp);
    apb(1'b0, OFF_FLAGS, 32'h0);
    `CHK(q[4:0], exp)
    apb(1'b1, OFF_FLAGS, 32'h1F);
  endtask : flg

  task automatic hold(input logic [11:0] v, input int n);
    u_pin_source.put(v);
    repeat (n) @(posedge pclk);
  endtask : hold

  task automatic sby(input logic [11:0] v, input logic exp);
    int w;
    apb(1'b1, OFF_STANDBY, 32'h1);
    w = wake_cnt;
    repeat (2) @(posedge pclk);
    `CHK(standby, 1'b1)
    hold(v, 8);
    `CHK(standby, !exp)
    `CHK(wake_cnt != w, exp)
    apb(1'b0, OFF_STANDBY, 32'h0);
    `CHK(q[0], !exp)
    hold(I, 8);
    apb(1'b1, OFF_FLAGS, 32'h1F);
  endtask : sby

  // ****************************************************
  // Sequence
  // ****************************************************
  initial begin
    logic [1:0] md;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_EDGE_FIRST, 32'h0);
    `CHK(q[3:0], 4'h0)
    apb(1'b0, OFF_EDGE_SECOND, 32'h0);
    `CHK(q[0], 1'b0)
    apb(1'b0, OFF_EDGE_TK, 32'h0);
    `CHK(q[1:0], 2'h0)
    `CHK(key_oe, 8'h00)
    apb(1'b0, OFF_PINS, 32'h0);
    `CHK(q[11:0], I)
    flg(5'h00);
    apb(1'b1, 8'h40, 32'hF);
    `CHK(err, 1'b1)
    hold(I | 12'h1, 8);
    flg(5'h01);
    hold(I, 8);
    flg(5'h01);
    hold(I | 12'h1, 20);
    `CHK(vector_req, 3'h1)
    vector_ack <= 3'h1;
    @(posedge pclk);
    vector_ack <= 3'h0;
    repeat (3) @(posedge pclk);
    `CHK(vector_req, 3'h0)
    hold(I, 8);
    flg(5'h01);
    for (int m = 0; m < 4; m++) begin
      md = 2'(m);
      apb(1'b1, OFF_EDGE_FIRST, {30'h0, md});
      hold(I | 12'h2, 8);
      flg({3'h0, md == MODE_RISE || md == MODE_BOTH, 1'b0});
      hold(I, 8);
      flg({3'h0, md == MODE_FALL || md == MODE_BOTH, 1'b0});
    end
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, OFF_EDGE_SECOND, 32'(m));
      hold(I | 12'h4, 8);
      flg({2'h0, m == 0, 2'h0});
      hold(I, 8);
      flg({2'h0, m == 1, 2'h0});
    end
    apb(1'b1, OFF_EDGE_TK, 32'h0);
    hold(I | 12'h8, 8);
    `CHK(test_edge_flag, 1'b1)
    flg(5'h08);
    hold(I, 8);
    flg(5'h00);
    apb(1'b1, OFF_EDGE_TK, 32'h2);
    hold(I | 12'h8, 8);
    flg(5'h00);
    hold(I, 8);
    for (int k = 0; k < 8; k++) begin
      hold(I & ~(12'h010 << k), 8);
      `CHK(key_flag, 1'b1)
      `CHK(vector_req, 3'h0)
      flg(5'h10);
      hold(I, 8);
    end
    apb(1'b1, OFF_EDGE_TK, 32'h1);
    hold(12'hEF0, 8);
    flg(5'h18);
    hold(I, 8);
    // Filtered input: pulse too short for two agreeing samples
    apb(1'b1, OFF_EDGE_FIRST, 32'h4);
    hold(I | 12'h2, 1);
    hold(I, 40);
    flg(5'h00);
    hold(I | 12'h2, 40);
    flg(5'h02);
    hold(I, 40);
    apb(1'b1, OFF_EDGE_FIRST, 32'hC);
    hold(I | 12'h2, 16);
    hold(I, 150);
    flg(5'h00);
    hold(I | 12'h2, 150);
    flg(5'h02);
    hold(I, 150);
    apb(1'b1, OFF_EDGE_FIRST, 32'h4);
    sby(I | 12'h2, 1'b0);
    sby(I | 12'h1, 1'b1);
    apb(1'b1, OFF_EDGE_FIRST, 32'h0);
    sby(I | 12'h2, 1'b1);
    apb(1'b1, OFF_EDGE_SECOND, 32'h0);
    sby(I | 12'h4, 1'b1);
    apb(1'b1, OFF_EDGE_TK, 32'h0);
    sby(I | 12'h8, 1'b1);
    apb(1'b1, OFF_EDGE_FIRST, 32'h1);
    apb(1'b1, OFF_EDGE_SECOND, 32'h1);
    hold(I | 12'h1, 8);
    hold(I, 8);
    apb(1'b1, OFF_KEY_DIR, 32'h1);
    apb(1'b1, OFF_STANDBY, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK(key_oe, 8'hFF)
    `CHK(standby, 1'b1)
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(vector_req, 3'h0)
    `CHK(standby, 1'b0)
    presetn <= 1'b1;
    `CHK(key_oe, 8'h00)
    apb(1'b0, OFF_STANDBY, 32'h0);
    `CHK(q[0], 1'b0)
    apb(1'b0, OFF_EDGE_FIRST, 32'h0);
    `CHK(q[3:0], 4'h0)
    apb(1'b0, OFF_EDGE_SECOND, 32'h0);
    `CHK(q[0], 1'b0)
    flg(5'h00);
    end_sim();
  end
endmodule : edge_irq_detect_tb
